// ===== verilog/mad_datapath.sv
`timescale 1ns/1ns
// Summary of operation
// - multiply each operand pair and add or subtract all products into one result
// - widths up to 25 (27 with two extension bits) use one native multiply; no separate small path
// - operands above 25 bits are split into partial products and recombined
// - input, sign, add/sub and product registers inside; one result register
// - operand and result widths 1 to 256, each input signed or unsigned
// - variable sign option lets a run-time input pick signed or unsigned
// - variable operation option lets a run-time input pick add or subtract
// - optional clock enable and clear, clear asynchronous or synchronous
// - default pre-adder mode is bypass, operands straight from data inputs
// - coefficient mode multiplies pre-adder sum by one of 8 stored constants
// - input mode multiplies pre-adder sum by the third operand input
// - square mode squares the pre-adder sum of each multiplier
// - constant mode multiplies a direct operand by a stored constant
// - systolic element n has its product delayed by NUM_MULT-1-n cycles
// - chain adder adds local results to the registered cascade input
// - systolic delays exist only for sums of two or four multipliers
// - two systolic: pair one now plus pair zero one cycle earlier
// - four systolic: pair three now, pairs two, one, zero delayed 1, 2, 3
// - load constant replaces the accumulator feedback with two to the exponent
// - exponent ranges 0 to 64, and 64 yields a zero constant
// - double accumulator adds a feedback register one valid load behind the output
// - each stage register uses asynchronous or synchronous clear, never both; the operand buffer ignores clear

module mad_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = mad_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ready_reg;
  logic push;
  logic pop;

  assign push = in_valid && ready_reg;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign in_ready = ready_reg;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
    end
  end

  // ready is registered so the source sees back-pressure from a flop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      ready_reg <= mad_pkg::RST_READY;
    end else begin
      count_reg <= count_next;
      ready_reg <= (count_next < CW'(DEPTH));
    end
  end
endmodule

module mad_datapath #(
  parameter int NUM_MULT = mad_pkg::DEF_MULT,
  parameter int A_WIDTH = mad_pkg::DEF_A_WIDTH,
  parameter int B_WIDTH = mad_pkg::DEF_B_WIDTH,
  parameter int RESULT_WIDTH = mad_pkg::DEF_RESULT_WIDTH,
  parameter mad_pkg::mad_preadd_mode_t PRE_MODE = mad_pkg::PRE_SIMPLE,
  parameter mad_pkg::mad_rep_t A_REP = mad_pkg::REP_UNSIGNED,
  parameter mad_pkg::mad_rep_t B_REP = mad_pkg::REP_UNSIGNED,
  parameter mad_pkg::mad_op_t PAIR1_OP = mad_pkg::OP_ADD,
  parameter mad_pkg::mad_op_t PAIR2_OP = mad_pkg::OP_ADD,
  parameter bit USE_SUBADD = 1'b0,
  parameter bit USE_ENA = 1'b0,
  parameter mad_pkg::mad_clear_kind_t CLEAR_KIND = mad_pkg::CLR_ASYNC,
  parameter bit SYSTOLIC = 1'b0,
  parameter bit DOUBLE_ACC = 1'b0,
  parameter int LOADCONST_VALUE = mad_pkg::LOADCONST_MAX_EXP,
  parameter logic [mad_pkg::MAX_MULT*mad_pkg::COEF_COUNT*B_WIDTH-1:0] COEFS = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register controls
  input wire logic clear,
  input wire logic ena,
  // operand stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [NUM_MULT*A_WIDTH-1:0] in_a,
  input wire logic [NUM_MULT*B_WIDTH-1:0] in_b,
  input wire logic [NUM_MULT*B_WIDTH-1:0] in_c,
  input wire mad_pkg::mad_ctrl_t in_ctrl,
  // cascade
  input wire logic [RESULT_WIDTH-1:0] chain_in,
  output logic [RESULT_WIDTH-1:0] chain_out,
  // result
  output logic [RESULT_WIDTH-1:0] result,
  output logic result_valid
);
  localparam int CTW = $bits(mad_pkg::mad_ctrl_t);
  localparam int AFW = NUM_MULT * A_WIDTH;
  localparam int BFW = NUM_MULT * B_WIDTH;
  localparam int FW = CTW + AFW + 2 * BFW;
  localparam int XW = ((A_WIDTH > B_WIDTH) ? A_WIDTH : B_WIDTH) + 2;
  localparam int PW = 2 * XW;
  localparam int SW = PW + 3;
  localparam int NL = (XW + mad_pkg::NATIVE_LARGE_W - 1) / mad_pkg::NATIVE_LARGE_W;
  localparam int RW = RESULT_WIDTH;
  localparam bit SYS_ON = SYSTOLIC && (NUM_MULT == 2 || NUM_MULT == 4);
  localparam logic [RW-1:0] LOAD_K =
    (LOADCONST_VALUE >= mad_pkg::LOADCONST_MAX_EXP || LOADCONST_VALUE >= RW) ? '0 :
    (RW'(1) << LOADCONST_VALUE);

  // one clear input whose kind is fixed at build time
  logic clr_n;
  logic sclr;
  logic adv;
  assign clr_n = arst_n && !((CLEAR_KIND == mad_pkg::CLR_ASYNC) && clear);
  assign sclr = (CLEAR_KIND == mad_pkg::CLR_SYNC) && clear;
  assign adv = !USE_ENA || ena;

  // operand buffer; a low enable stalls the drain so back-pressure reaches in_ready
  logic fifo_valid;
  logic [FW-1:0] fifo_data;
  mad_fifo #(.WIDTH(FW), .DEPTH(mad_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_ctrl, in_c, in_b, in_a}),
    .out_valid(fifo_valid),
    .out_ready(adv),
    .out_data(fifo_data)
  );

  // input register stage (data, sign and add/sub selects)
  logic [AFW-1:0] s1_a_reg;
  logic [BFW-1:0] s1_b_reg;
  logic [BFW-1:0] s1_c_reg;
  mad_pkg::mad_ctrl_t s1_ctrl_reg;
  logic s1_valid_reg;

  // all data inputs share ref_clk, as pre-adder modes expect
  always_ff @(posedge ref_clk or negedge clr_n) begin
    if (!clr_n) begin
      s1_a_reg <= '0;
      s1_b_reg <= '0;
      s1_c_reg <= '0;
      s1_ctrl_reg <= '0;
      s1_valid_reg <= mad_pkg::RST_VALID;
    end else if (sclr) begin
      s1_a_reg <= '0;
      s1_b_reg <= '0;
      s1_c_reg <= '0;
      s1_ctrl_reg <= '0;
      s1_valid_reg <= mad_pkg::RST_VALID;
    end else if (adv) begin
      s1_a_reg <= fifo_data[AFW-1:0];
      s1_b_reg <= fifo_data[AFW +: BFW];
      s1_c_reg <= fifo_data[AFW + BFW +: BFW];
      s1_ctrl_reg <= fifo_data[FW-1 -: CTW];
      s1_valid_reg <= fifo_valid;
    end
  end

  // run-time or fixed operand interpretation
  logic sign_a_eff;
  logic sign_b_eff;
  assign sign_a_eff = (A_REP == mad_pkg::REP_VARIABLE) ? s1_ctrl_reg.sign_a :
                      (A_REP == mad_pkg::REP_SIGNED);
  assign sign_b_eff = (B_REP == mad_pkg::REP_VARIABLE) ? s1_ctrl_reg.sign_b :
                      (B_REP == mad_pkg::REP_SIGNED);

  function automatic logic signed [XW-1:0] ext_a(input logic [A_WIDTH-1:0] v, input logic s);
    ext_a = s ? {{(XW - A_WIDTH){v[A_WIDTH-1]}}, v} : {{(XW - A_WIDTH){1'b0}}, v};
  endfunction

  function automatic logic signed [XW-1:0] ext_b(input logic [B_WIDTH-1:0] v, input logic s);
    ext_b = s ? {{(XW - B_WIDTH){v[B_WIDTH-1]}}, v} : {{(XW - B_WIDTH){1'b0}}, v};
  endfunction

  // native multiply for narrow operands, 27-bit limbs of |y| beyond that;
  // wide limbs cost timing, which is why narrow widths stay native
  function automatic logic signed [PW-1:0] mul_pp(
    input logic signed [XW-1:0] x,
    input logic signed [XW-1:0] y
  );
    logic [NL*mad_pkg::NATIVE_LARGE_W-1:0] mag;
    logic signed [PW-1:0] acc;
    logic signed [PW-1:0] limb;
    int i;
    mag = '0;
    acc = '0;
    limb = '0;
    if (XW <= mad_pkg::NATIVE_LARGE_W) begin
      acc = PW'(x) * PW'(y);
    end else begin
      mag[XW-1:0] = y[XW-1] ? XW'(-y) : XW'(y);
      for (i = 0; i < NL; i++) begin
        limb = PW'($signed({1'b0, mag[i*mad_pkg::NATIVE_LARGE_W +: mad_pkg::NATIVE_LARGE_W]}));
        acc = acc + ((PW'(x) * limb) <<< (i * mad_pkg::NATIVE_LARGE_W));
      end
      if (y[XW-1]) begin
        acc = -acc;
      end
    end
    mul_pp = acc;
  endfunction

  // product register stage
  logic signed [PW-1:0] prod_comb [NUM_MULT];
  logic signed [PW-1:0] s2_prod_reg [NUM_MULT];
  logic signed [PW-1:0] prod_al [NUM_MULT];
  mad_pkg::mad_ctrl_t s2_ctrl_reg;
  logic s2_valid_reg;

  for (genvar n = 0; n < NUM_MULT; n++) begin : g_mult
    logic signed [XW-1:0] a_x;
    logic signed [XW-1:0] b_x;
    logic signed [XW-1:0] c_x;
    logic signed [XW-1:0] k_x;
    logic signed [XW-1:0] pre_sum;
    logic [mad_pkg::COEF_SEL_W-1:0] sel;
    localparam int D = SYS_ON ? NUM_MULT - 1 - n : 0;

    assign sel = s1_ctrl_reg.coef_sel[n*mad_pkg::COEF_SEL_W +: mad_pkg::COEF_SEL_W];
    assign a_x = ext_a(s1_a_reg[n*A_WIDTH +: A_WIDTH], sign_a_eff);
    assign b_x = ext_b(s1_b_reg[n*B_WIDTH +: B_WIDTH], sign_b_eff);
    assign c_x = ext_b(s1_c_reg[n*B_WIDTH +: B_WIDTH], sign_b_eff);
    assign k_x = ext_b(COEFS[(n*mad_pkg::COEF_COUNT + int'(sel))*B_WIDTH +: B_WIDTH],
                       sign_b_eff);
    assign pre_sum = a_x + b_x;

    always_comb begin
      case (PRE_MODE)
        mad_pkg::PRE_COEF: prod_comb[n] = mul_pp(pre_sum, k_x);
        mad_pkg::PRE_INPUT: prod_comb[n] = mul_pp(pre_sum, c_x);
        mad_pkg::PRE_SQUARE: prod_comb[n] = mul_pp(pre_sum, pre_sum);
        mad_pkg::PRE_CONST: prod_comb[n] = mul_pp(a_x, k_x);
        default: prod_comb[n] = mul_pp(a_x, b_x);
      endcase
    end

    always_ff @(posedge ref_clk or negedge clr_n) begin
      if (!clr_n) begin
        s2_prod_reg[n] <= '0;
      end else if (sclr) begin
        s2_prod_reg[n] <= '0;
      end else if (adv) begin
        s2_prod_reg[n] <= prod_comb[n];
      end
    end

    // earlier pairs wait longer, so pair n adds its term from NUM_MULT-1-n samples before the newest pair's
    if (D > 0) begin : g_sys
      logic signed [PW-1:0] dly_reg [D];
      always_ff @(posedge ref_clk or negedge clr_n) begin
        if (!clr_n) begin
          for (int j = 0; j < D; j++) begin
            dly_reg[j] <= '0;
          end
        end else if (sclr) begin
          for (int j = 0; j < D; j++) begin
            dly_reg[j] <= '0;
          end
        end else if (adv) begin
          dly_reg[0] <= s2_prod_reg[n];
          for (int j = 1; j < D; j++) begin
            dly_reg[j] <= dly_reg[j-1];
          end
        end
      end
      assign prod_al[n] = dly_reg[D-1];
    end else begin : g_nosys
      assign prod_al[n] = s2_prod_reg[n];
    end
  end

  always_ff @(posedge ref_clk or negedge clr_n) begin
    if (!clr_n) begin
      s2_ctrl_reg <= '0;
      s2_valid_reg <= mad_pkg::RST_VALID;
    end else if (sclr) begin
      s2_ctrl_reg <= '0;
      s2_valid_reg <= mad_pkg::RST_VALID;
    end else if (adv) begin
      s2_ctrl_reg <= s1_ctrl_reg;
      s2_valid_reg <= s1_valid_reg;
    end
  end

  // add/subtract decode; reversed polarity turns a high select into subtract
  logic sub1;
  logic sub2;
  assign sub1 = (PAIR1_OP == mad_pkg::OP_SUB) || ((PAIR1_OP == mad_pkg::OP_VARIABLE) &&
                (s2_ctrl_reg.pair_operation_select == USE_SUBADD));
  assign sub2 = (PAIR2_OP == mad_pkg::OP_SUB) || ((PAIR2_OP == mad_pkg::OP_VARIABLE) &&
                (s2_ctrl_reg.pair2_operation_select == USE_SUBADD));

  logic signed [SW-1:0] sum;
  always_comb begin
    sum = '0;
    for (int k = 0; k < NUM_MULT; k++) begin
      if ((k == 1 && sub1) || (k == 3 && sub2)) begin
        sum = sum - SW'(prod_al[k]);
      end else begin
        sum = sum + SW'(prod_al[k]);
      end
    end
  end

  // output register, optional second feedback register, cascade copy
  logic [RW-1:0] result_reg;
  logic [RW-1:0] dacc_reg;
  logic [RW-1:0] chain_reg;
  logic valid_reg;
  logic [RW-1:0] feedback;
  logic [RW-1:0] acc_operand;
  logic [RW-1:0] result_next;

  assign feedback = DOUBLE_ACC ? dacc_reg : result_reg;
  always_comb begin
    if (s2_ctrl_reg.load_const) begin
      acc_operand = LOAD_K;
    end else if (s2_ctrl_reg.accumulate) begin
      acc_operand = feedback;
    end else begin
      acc_operand = '0;
    end
    result_next = acc_operand + RW'(sum) + chain_in;
  end

  // only the first result register lives here; extra latency belongs outside
  always_ff @(posedge ref_clk or negedge clr_n) begin
    if (!clr_n) begin
      result_reg <= '0;
      chain_reg <= '0;
      dacc_reg <= '0;
      valid_reg <= mad_pkg::RST_VALID;
    end else if (sclr) begin
      result_reg <= '0;
      chain_reg <= '0;
      dacc_reg <= '0;
      valid_reg <= mad_pkg::RST_VALID;
    end else if (adv) begin
      valid_reg <= s2_valid_reg;
      if (s2_valid_reg) begin
        result_reg <= result_next;
        chain_reg <= result_next;
        dacc_reg <= result_reg;
      end
    end
  end

  assign result = result_reg;
  assign chain_out = chain_reg;
  assign result_valid = valid_reg;
endmodule

// ===== verilog/mad_pkg.sv
package mad_pkg;

  // structural limits of the datapath
  localparam int MAX_MULT = 4;
  localparam int COEF_COUNT = 8;
  localparam int COEF_SEL_W = 3;
  localparam int NATIVE_SMALL_W = 18;
  localparam int NATIVE_LARGE_W = 27;
  localparam int MAX_WIDTH = 256;
  localparam int LOADCONST_MAX_EXP = 64;
  localparam int FIFO_DEPTH = 8;

  // documented parameter defaults
  localparam int DEF_MULT = 1;
  localparam int DEF_A_WIDTH = 16;
  localparam int DEF_B_WIDTH = 16;
  localparam int DEF_RESULT_WIDTH = 32;

  // reset values
  localparam logic RST_VALID = 1'h0;
  localparam logic RST_READY = 1'h0;

  typedef enum logic [2:0] {
    PRE_SIMPLE,
    PRE_COEF,
    PRE_INPUT,
    PRE_SQUARE,
    PRE_CONST
  } mad_preadd_mode_t;

  typedef enum logic [1:0] {
    REP_UNSIGNED,
    REP_SIGNED,
    REP_VARIABLE
  } mad_rep_t;

  typedef enum logic [1:0] {
    OP_ADD,
    OP_SUB,
    OP_VARIABLE
  } mad_op_t;

  typedef enum logic {
    CLR_ASYNC,
    CLR_SYNC
  } mad_clear_kind_t;

  // run-time controls that travel with each operand set
  typedef struct packed {
    logic sign_a;
    logic sign_b;
    logic pair_operation_select;
    logic pair2_operation_select;
    logic accumulate;
    logic load_const;
    logic [MAX_MULT*COEF_SEL_W-1:0] coef_sel;
  } mad_ctrl_t;

endpackage

// ===== tb/mad_datapath_monitor.sv
`timescale 1ns/1ns
module mad_datapath_monitor #(
  parameter int RESULT_WIDTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // controls and stream
  input wire logic clear,
  input wire logic ena,
  input wire logic in_valid,
  input wire logic in_ready,
  // outputs
  input wire logic [RESULT_WIDTH-1:0] chain_out,
  input wire logic [RESULT_WIDTH-1:0] result,
  input wire logic result_valid
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_take;
    in_valid && in_ready;
  endsequence
  // 8 queued sets plus 3 stages: 11 flowing edges bring any accepted set out
  sequence s_flow;
    (ena && !clear) [*8] ##1 (ena && !clear) [*3];
  endsequence
  // edges since result_valid was last seen high, saturating; the earliest
  // result of a set appears 4 edges after it is taken, so a result inside the
  // window leaves this below 7 at the window's end
  logic [3:0] gap_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= 4'hf;
    end else if (result_valid) begin
      gap_reg <= 4'h0;
    end else if (gap_reg != 4'hf) begin
      gap_reg <= gap_reg + 4'h1;
    end
  end
  // 8 queued sets drain in 8 edges, then 4 more edges empty the 3 pipeline stages
  sequence s_quiet;
    (ena && !clear && !(in_valid && in_ready)) [*8] ##1
      (ena && !clear && !(in_valid && in_ready)) [*4];
  endsequence

  AST_CHAIN_COPY: assert property (chain_out == result)
    else $error("cascade output differs from result");
  AST_HOLD: assert property (!result_valid && !clear && !$past(clear) |-> $stable(result))
    else $error("result moved without a valid load");
  AST_FROZEN: assert property (disable iff (!arst_n || clear)
    !ena |=> $stable(result) && $stable(result_valid))
    else $error("outputs changed while enable was low");
  AST_CLEAR_ZERO: assert property (clear |-> result == '0 && !result_valid)
    else $error("clear did not empty the result");
  AST_RESET_OUT: assert property ($rose(arst_n) |-> result == '0 && !result_valid && !in_ready)
    else $error("outputs not idle after reset");
  AST_DRAIN: assert property (disable iff (!arst_n || clear)
    s_take ##1 s_flow |-> result_valid || (gap_reg < 4'h7))
    else $error("accepted set produced no result");
  AST_QUIET: assert property (disable iff (!arst_n || clear) s_quiet |=> !result_valid)
    else $error("result appeared with nothing in flight");
  AST_READY_FALL: assert property ($fell(in_ready) |-> $past(in_valid && in_ready))
    else $error("ready dropped without an accepted set");
  AST_READY_RISE: assert property ($rose(in_ready) && $past(arst_n, 2) |-> $past(ena))
    else $error("ready rose while the pipeline was frozen");
endmodule

bind mad_datapath mad_datapath_monitor #(.RESULT_WIDTH(RESULT_WIDTH)) u_mon (
  .ref_clk(ref_clk), .arst_n(arst_n), .clear(clear), .ena(ena), .in_valid(in_valid),
  .in_ready(in_ready), .chain_out(chain_out), .result(result), .result_valid(result_valid));

// ===== tb/mad_chain_src.sv
`timescale 1ns/1ns
module mad_chain_src #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // new partial sum of the neighbouring stage
  input wire logic load,
  input wire logic [W-1:0] value,
  // registered cascade sum
  output logic [W-1:0] chain
);
  // a neighbour's result register only moves when its own result does
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chain <= '0;
    end else if (load) begin
      chain <= value;
    end
  end
endmodule

// ===== tb/test_mad_datapath.sv
`timescale 1ns/1ns
module test_mad_datapath;
  localparam int RW = 32;
  localparam int LC_EXP = 4;
  logic ref_clk, arst_n, clear, ena, in_valid, in_ready, result_valid, chain_load, jitter;
  logic [15:0] in_a, in_b, in_c;
  logic [31:0] r;
  mad_pkg::mad_ctrl_t in_ctrl;
  logic [RW-1:0] chain_in, chain_out, result, chain_val, acc_model, e;
  logic [RW-1:0] sq_result, acc_sq0, acc_sq1, esq;
  logic sq_valid;
  logic [RW-1:0] expq[$];
  logic [RW-1:0] sqq[$];
  int fails, checks, seed, cycles;

  mad_chain_src #(.W(RW)) u_src (.ref_clk(ref_clk), .arst_n(arst_n), .load(chain_load),
    .value(chain_val), .chain(chain_in));
  mad_datapath #(.NUM_MULT(2), .A_WIDTH(8), .B_WIDTH(8), .RESULT_WIDTH(RW),
    .A_REP(mad_pkg::REP_VARIABLE), .B_REP(mad_pkg::REP_VARIABLE),
    .PAIR1_OP(mad_pkg::OP_VARIABLE), .USE_ENA(1'b1), .LOADCONST_VALUE(LC_EXP)) u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(clear), .ena(ena), .in_valid(in_valid),
    .in_ready(in_ready), .in_a(in_a), .in_b(in_b), .in_c(in_c), .in_ctrl(in_ctrl),
    .chain_in(chain_in), .chain_out(chain_out), .result(result), .result_valid(result_valid));
  // same stream into a squaring pre-adder with the second feedback register
  mad_datapath #(.NUM_MULT(2), .A_WIDTH(8), .B_WIDTH(8), .RESULT_WIDTH(RW),
    .PRE_MODE(mad_pkg::PRE_SQUARE), .A_REP(mad_pkg::REP_VARIABLE),
    .B_REP(mad_pkg::REP_VARIABLE), .PAIR1_OP(mad_pkg::OP_VARIABLE), .USE_ENA(1'b1),
    .DOUBLE_ACC(1'b1), .LOADCONST_VALUE(LC_EXP)) u_dut_sq (
    .ref_clk(ref_clk), .arst_n(arst_n), .clear(clear), .ena(ena), .in_valid(in_valid),
    .in_ready(), .in_a(in_a), .in_b(in_b), .in_c(in_c), .in_ctrl(in_ctrl),
    .chain_in(chain_in), .chain_out(), .result(sq_result), .result_valid(sq_valid));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [RW-1:0] seen, input logic [RW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reference sum of the two products, taken with the set's own controls
  function automatic logic [RW-1:0] model(input bit sq);
    longint a, b, p, s, acc;
    s = 0;
    for (int n = 0; n < 2; n++) begin
      a = in_ctrl.sign_a ? longint'($signed(in_a[n*8+:8])) : longint'(in_a[n*8+:8]);
      b = in_ctrl.sign_b ? longint'($signed(in_b[n*8+:8])) : longint'(in_b[n*8+:8]);
      p = sq ? (a + b) * (a + b) : a * b;
      if (n == 1 && !in_ctrl.pair_operation_select)
        s = s - p;
      else
        s = s + p;
    end
    // the double register feeds back the result from two loads ago
    acc = in_ctrl.accumulate ? longint'(sq ? acc_sq1 : acc_model) : 0;
    if (in_ctrl.load_const)
      acc = longint'(1) << LC_EXP;
    if (sq) begin
      acc_sq1 = acc_sq0;
      acc_sq0 = RW'(acc + s + longint'(chain_in));
      return acc_sq0;
    end
    acc_model = RW'(acc + s + longint'(chain_in));
    return acc_model;
  endfunction

  always @(posedge ref_clk)
    if (arst_n && in_valid === 1'b1 && in_ready === 1'b1) begin
      expq.push_back(model(1'b0));
      sqq.push_back(model(1'b1));
    end

  always @(posedge ref_clk) begin
    if (arst_n && sq_valid === 1'b1 && ena === 1'b1) begin
      esq = (sqq.size() > 0) ? sqq.pop_front() : 'x;
      check(sq_result, esq);
    end
  end

  // a held result is counted once, at the edge that moves it on
  always @(posedge ref_clk) begin
    if (arst_n && result_valid === 1'b1 && ena === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 'x;
      check(result, e);
      check(chain_out, e);
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      report_and_stop();
    end
  end

  always @(negedge ref_clk)
    if (jitter)
      ena = 1'($random(seed));

  task automatic send(input int n);
    int guard;
    repeat (n) begin
      @(negedge ref_clk);
      r = $random(seed);
      in_a = r[15:0];
      in_b = r[31:16];
      r = $random(seed);
      in_c = r[15:0];
      r = $random(seed);
      in_ctrl = r[$bits(mad_pkg::mad_ctrl_t)-1:0];
      in_valid = 1'b1;
      guard = 0;
      @(posedge ref_clk);
      while (in_ready !== 1'b1 && guard < 60) begin
        @(posedge ref_clk);
        guard++;
      end
      if (in_ready !== 1'b1)
        fails++;
    end
  endtask

  task automatic idle(input int n);
    @(negedge ref_clk);
    in_valid = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic set_chain(input logic [RW-1:0] v);
    @(negedge ref_clk);
    chain_val = v;
    chain_load = 1'b1;
    @(negedge ref_clk);
    chain_load = 1'b0;
  endtask

  initial begin
    seed = 55126;
    fails = 0;
    checks = 0;
    cycles = 0;
    acc_model = '0;
    acc_sq0 = '0;
    acc_sq1 = '0;
    arst_n = 1'b0;
    clear = 1'b0;
    ena = 1'b1;
    jitter = 1'b0;
    in_valid = 1'b0;
    in_a = '0;
    in_b = '0;
    in_c = '0;
    in_ctrl = '0;
    chain_load = 1'b0;
    chain_val = '0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    send(40);
    idle(14);
    set_chain(32'h0001_2345);
    jitter = 1'b1;
    send(40);
    // ena only moves on a falling edge, away from the edge that samples it
    jitter = 1'b0;
    @(negedge ref_clk);
    ena = 1'b1;
    in_valid = 1'b0;
    idle(14);
    // freeze the drain so the buffer fills to its depth and refuses
    ena = 1'b0;
    send(mad_pkg::FIFO_DEPTH);
    @(negedge ref_clk);
    check(RW'(in_ready), '0);
    repeat (3) @(negedge ref_clk);
    check(RW'(in_ready), '0);
    ena = 1'b1;
    send(10);
    idle(16);
    clear = 1'b1;
    @(negedge ref_clk);
    check(result, '0);
    check(RW'(result_valid), '0);
    clear = 1'b0;
    acc_model = '0;
    acc_sq0 = '0;
    acc_sq1 = '0;
    set_chain(32'hfff0_0001);
    send(12);
    idle(16);
    check(RW'(expq.size()), '0);
    check(RW'(sqq.size()), '0);
    report_and_stop();
  end
endmodule
